// >>> rtl/thermistor_consts.vh
// constants for the thermistor acquisition control block
// assumes a 100 MHz clock and an AXI4-Lite register port
`ifndef THERMISTOR_CONSTS_VH
`define THERMISTOR_CONSTS_VH

// ============================================================
// bus geometry
`define AXI_ADDR_W 8
`define AXI_DATA_W 32
`define IDX_W 6
`define REG_W 8
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ============================================================
// register indices, byte address is four times the index
`define IDX_ACQ_CTRL 6'h0D
`define IDX_THRESH 6'h0E
`define IDX_IRQ_STATUS 6'h11
`define IDX_IRQ_MASK 6'h12
`define IDX_TEMP_VIEW 6'h13

// ============================================================
// acquisition control fields
`define ACQ_START_BIT 7
`define ACQ_DONE_BIT 5
`define ACQ_DT_MSB 1
`define ACQ_DT_LSB 0
`define ACQ_SPARE_MASK 8'h5C
`define ACQ_CTRL_RESET 8'h20
`define DT_BASE_C 8'h02

// ============================================================
// threshold register fields
`define THR_RESET 8'h78
`define THR_HOT_MSB 3
`define THR_HOT_LSB 0
`define HOT_BASE_C 8'h2A

// ============================================================
// interrupt bits
`define IRQ_W 3
`define IRQ_EOC 0
`define IRQ_DTX 1
`define IRQ_HOT 2

// ============================================================
// sequencer states
`define SEQ_IDLE 1'b0
`define SEQ_WAIT 1'b1

`endif

// >>> rtl/temp_conv_sequencer.v
// one-shot conversion sequencer in front of the temperature adc
// assumes the adc logic runs on clk_i and answers with a valid pulse
`timescale 1ns/100ps
`default_nettype none
`include "thermistor_consts.vh"

module temp_conv_sequencer (
	// clock and reset
	input wire clk_i,
	input wire reset_n_i,
	// control
	input wire start_i,
	output wire busy_o,
	output reg done_o,
	output reg [`REG_W-1:0] result_o,
	// adc side
	output wire conv_req_o,
	input wire conv_valid_i,
	input wire [`REG_W-1:0] conv_data_i
);

	reg state_r; // idle or waiting for the adc
	localparam [0:0] ST_IDLE = `SEQ_IDLE; // no conversion pending
	localparam [0:0] ST_WAIT = `SEQ_WAIT; // request out, awaiting a reading

	// ============================================================
	// request held until the adc answers
	assign conv_req_o = (state_r == ST_WAIT);
	assign busy_o = (state_r == ST_WAIT);

	// state, result capture and done pulse
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_r <= ST_IDLE;
			done_o <= 1'b0;
			result_o <= 8'h00;
		end else begin
			done_o <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					if (start_i) begin
						state_r <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					// stray valids while idle are ignored
					if (conv_valid_i) begin
						result_o <= conv_data_i;
						done_o <= 1'b1;
						state_r <= ST_IDLE;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

endmodule // temp_conv_sequencer
`default_nettype wire

// >>> rtl/axil_reg_port.v
// axi4-lite slave front end, one write and one read in flight
// assumes the register core decodes addresses combinationally
`timescale 1ns/100ps
`default_nettype none
`include "thermistor_consts.vh"

module axil_reg_port (
	// clock and reset
	input wire clk_i,
	input wire reset_n_i,
	// write address and data
	input wire awvalid_i,
	output wire awready_o,
	input wire [`AXI_ADDR_W-1:0] awaddr_i,
	input wire wvalid_i,
	output wire wready_o,
	input wire [`AXI_DATA_W-1:0] wdata_i,
	input wire [3:0] wstrb_i,
	// write response
	output reg bvalid_o,
	input wire bready_i,
	output reg [1:0] bresp_o,
	// read address and data
	input wire arvalid_i,
	output wire arready_o,
	input wire [`AXI_ADDR_W-1:0] araddr_i,
	output reg rvalid_o,
	input wire rready_i,
	output reg [`AXI_DATA_W-1:0] rdata_o,
	output reg [1:0] rresp_o,
	// core side
	output wire wr_en_o,
	output wire [`IDX_W-1:0] wr_idx_o,
	output wire [`REG_W-1:0] wr_data_o,
	input wire wr_err_i,
	output wire rd_en_o,
	output wire [`IDX_W-1:0] rd_idx_o,
	input wire [`REG_W-1:0] rd_data_i,
	input wire rd_err_i
);

	reg aw_held_r; // address captured
	reg w_held_r; // data captured
	reg [`IDX_W-1:0] aw_idx_r; // captured word index
	reg [`REG_W-1:0] w_data_r; // captured low byte
	reg w_lane0_r; // low byte lane enabled

	// ============================================================
	// handshakes; channels refused while a response is pending
	assign awready_o = !aw_held_r && !bvalid_o;
	assign wready_o = !w_held_r && !bvalid_o;
	assign arready_o = !rvalid_o;
	assign wr_en_o = aw_held_r && w_held_r && !bvalid_o && w_lane0_r;
	assign wr_idx_o = aw_idx_r;
	assign wr_data_o = w_data_r;
	assign rd_en_o = arvalid_i && arready_o;
	assign rd_idx_o = araddr_i[`AXI_ADDR_W-1:2];

	// write path
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_idx_r <= 6'h00;
			w_data_r <= 8'h00;
			w_lane0_r <= 1'b0;
			bvalid_o <= 1'b0;
			bresp_o <= `RESP_OKAY;
		end else begin
			if (awvalid_i && awready_o) begin
				aw_held_r <= 1'b1;
				aw_idx_r <= awaddr_i[`AXI_ADDR_W-1:2];
			end
			if (wvalid_i && wready_o) begin
				w_held_r <= 1'b1;
				w_data_r <= wdata_i[`REG_W-1:0];
				w_lane0_r <= wstrb_i[0];
			end
			if (aw_held_r && w_held_r && !bvalid_o) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				bvalid_o <= 1'b1;
				bresp_o <= wr_err_i ? `RESP_SLVERR : `RESP_OKAY;
			end else if (bvalid_o && bready_i) begin
				bvalid_o <= 1'b0;
			end
		end
	end

	// read path, data taken in the address cycle
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rvalid_o <= 1'b0;
			rdata_o <= 32'h00000000;
			rresp_o <= `RESP_OKAY;
		end else if (rd_en_o) begin
			rvalid_o <= 1'b1;
			rdata_o <= {24'h000000, rd_data_i};
			rresp_o <= rd_err_i ? `RESP_SLVERR : `RESP_OKAY;
		end else if (rvalid_o && rready_i) begin
			rvalid_o <= 1'b0;
		end
	end

endmodule // axil_reg_port
`default_nettype wire

// >>> rtl/thermistor_acquire_control.v
// thermistor acquisition control: start bit, done flag, thresholds,
// temperature-change and hot detection, sticky interrupts
// assumes the adc delivers 8-bit two's complement degrees C on clk_i
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "thermistor_consts.vh"

// Functional notes
// - writing one to start launches acquisition
// - start bit self-clears when acquisition completes
// - done flag read-only, zero while busy, resets one
// - two-bit change threshold selects 2 to 5 degrees
// - change interrupt when reading departs baseline enough
// - control register at 0x0D, reset 0x20
// - threshold register at 0x0E, reset 0x78
// - completion sets end-of-conversion status bit
// - interrupt when temperature reaches hot threshold
module thermistor_acquire_control (
	// clock and reset
	input wire clk_i,
	input wire reset_n_i,
	// axi4-lite write address
	input wire awvalid_i,
	output wire awready_o,
	input wire [`AXI_ADDR_W-1:0] awaddr_i,
	// axi4-lite write data
	input wire wvalid_i,
	output wire wready_o,
	input wire [`AXI_DATA_W-1:0] wdata_i,
	input wire [3:0] wstrb_i,
	// axi4-lite write response
	output wire bvalid_o,
	input wire bready_i,
	output wire [1:0] bresp_o,
	// axi4-lite read address
	input wire arvalid_i,
	output wire arready_o,
	input wire [`AXI_ADDR_W-1:0] araddr_i,
	// axi4-lite read data
	output wire rvalid_o,
	input wire rready_i,
	output wire [`AXI_DATA_W-1:0] rdata_o,
	output wire [1:0] rresp_o,
	// temperature adc
	output wire conv_req_o,
	input wire conv_valid_i,
	input wire [`REG_W-1:0] conv_data_i,
	// interrupt
	output reg irq_o
);

	// ============================================================
	// helper functions

	// magnitude of the difference of two signed readings
	// nine bits wide so the two signed extremes cannot wrap
	function [8:0] abs_diff;
		input [7:0] a;
		input [7:0] b;
		reg [8:0] d;
		begin
			d = {a[7], a} - {b[7], b};
			abs_diff = d[8] ? (9'h000 - d) : d;
		end
	endfunction

	// true when an index names a mapped register
	function is_mapped;
		input [`IDX_W-1:0] idx;
		begin
			case (idx)
				`IDX_ACQ_CTRL: is_mapped = 1'b1;
				`IDX_THRESH: is_mapped = 1'b1;
				`IDX_IRQ_STATUS: is_mapped = 1'b1;
				`IDX_IRQ_MASK: is_mapped = 1'b1;
				`IDX_TEMP_VIEW: is_mapped = 1'b1;
				default: is_mapped = 1'b0;
			endcase
		end
	endfunction

	// one-cycle write strobe for a given register index
	function write_hit;
		input en;
		input [`IDX_W-1:0] idx;
		input [`IDX_W-1:0] target;
		begin
			write_hit = en && (idx == target);
		end
	endfunction

	// ============================================================
	// reset image of the control register
	// one byte split per field, so the field resets cannot drift apart
	localparam [`REG_W-1:0] CTRL_RESET = `ACQ_CTRL_RESET;

	// ============================================================
	// declarations

	// bus core side
	wire wr_en; // one-cycle register write
	wire [`IDX_W-1:0] wr_idx; // written word index
	wire [`REG_W-1:0] wr_data; // written byte
	wire rd_en; // read taken this cycle
	wire [`IDX_W-1:0] rd_idx; // read word index
	reg [`REG_W-1:0] rd_data; // decoded read byte

	// register state
	reg start_r; // start bit, high while acquiring
	reg done_r; // conversion finished flag
	reg [`REG_W-1:0] spare_r; // unused read/write bits
	reg [1:0] dt_code_r; // change threshold code
	reg [`REG_W-1:0] thresh_r; // cold and hot thresholds
	reg [`IRQ_W-1:0] irq_stat_r; // sticky events
	reg [`IRQ_W-1:0] irq_mask_r; // event enables

	// reading history
	reg [`REG_W-1:0] baseline_r; // reference reading
	reg base_valid_r; // a baseline exists

	// sequencer link
	wire seq_busy; // conversion in progress
	wire seq_done; // one-cycle completion
	wire [`REG_W-1:0] seq_result; // latest reading
	wire start_pulse; // launch request

	// event detection
	wire [7:0] dt_limit; // change threshold in degrees
	wire [7:0] hot_limit; // hot threshold in degrees
	wire [8:0] change_mag; // |latest - baseline|
	wire dtx_hit; // change large enough
	wire hot_hit; // reading at or above hot
	wire [`IRQ_W-1:0] irq_set; // events this cycle
	wire [`IRQ_W-1:0] irq_clr; // write-one-to-clear mask
	wire wr_ctrl; // write to control register

	// register write strobes
	wire wr_thresh; // write to threshold register
	wire wr_status; // write to interrupt status
	wire wr_mask; // write to interrupt mask

	// ============================================================
	// bus front end
	// unmapped indices answer with an error; the port never stalls on them
	// is_mapped only flags the error on both paths; the read mux decodes rd_idx itself
	axil_reg_port u_port (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.awvalid_i(awvalid_i),
		.awready_o(awready_o),
		.awaddr_i(awaddr_i),
		.wvalid_i(wvalid_i),
		.wready_o(wready_o),
		.wdata_i(wdata_i),
		.wstrb_i(wstrb_i),
		.bvalid_o(bvalid_o),
		.bready_i(bready_i),
		.bresp_o(bresp_o),
		.arvalid_i(arvalid_i),
		.arready_o(arready_o),
		.araddr_i(araddr_i),
		.rvalid_o(rvalid_o),
		.rready_i(rready_i),
		.rdata_o(rdata_o),
		.rresp_o(rresp_o),
		.wr_en_o(wr_en),
		.wr_idx_o(wr_idx),
		.wr_data_o(wr_data),
		.wr_err_i(!is_mapped(wr_idx)),
		.rd_en_o(rd_en),
		.rd_idx_o(rd_idx),
		.rd_data_i(rd_data),
		.rd_err_i(!is_mapped(rd_idx))
	);

	// ============================================================
	// conversion sequencer
	// the sequencer owns the adc request; start_pulse is its only launch
	// a reading that arrives while idle is dropped there, not here
	temp_conv_sequencer u_seq (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.start_i(start_pulse),
		.busy_o(seq_busy),
		.done_o(seq_done),
		.result_o(seq_result),
		.conv_req_o(conv_req_o),
		.conv_valid_i(conv_valid_i),
		.conv_data_i(conv_data_i)
	);

	// ============================================================
	// start handling

	// one decode shared by every register writer
	assign wr_ctrl = write_hit(wr_en, wr_idx, `IDX_ACQ_CTRL);
	assign wr_thresh = write_hit(wr_en, wr_idx, `IDX_THRESH);
	assign wr_status = write_hit(wr_en, wr_idx, `IDX_IRQ_STATUS);
	assign wr_mask = write_hit(wr_en, wr_idx, `IDX_IRQ_MASK);
	// a write with the low byte lane off never raises wr_en:
	// it is answered on the bus but changes nothing

	// a one launches; zero, or a one while busy, does nothing
	// re-launch while busy is dropped so one result pairs one start
	assign start_pulse = wr_ctrl && wr_data[`ACQ_START_BIT]
		&& !start_r && !seq_busy;

	// control register fields
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			start_r <= CTRL_RESET[`ACQ_START_BIT];
			done_r <= CTRL_RESET[`ACQ_DONE_BIT];
			spare_r <= CTRL_RESET & `ACQ_SPARE_MASK;
			dt_code_r <= CTRL_RESET[`ACQ_DT_MSB:`ACQ_DT_LSB];
		end else begin
			// launch and completion never meet: done pulses only
			// while start_r is still set, which blocks start_pulse
			if (start_pulse) begin
				start_r <= 1'b1;
				done_r <= 1'b0;
			end else if (seq_done) begin
				start_r <= 1'b0;
				done_r <= 1'b1;
			end
			if (wr_ctrl) begin
				// done flag is not writable from the bus
				spare_r <= wr_data & `ACQ_SPARE_MASK;
				dt_code_r <= wr_data[`ACQ_DT_MSB:`ACQ_DT_LSB];
			end
		end
	end

	// threshold register
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			thresh_r <= `THR_RESET;
		end else if (wr_thresh) begin
			// cold nibble is stored only; no cold event is raised
			thresh_r <= wr_data;
		end
	end

	// ============================================================
	// event detection on each completed reading

	// both limits are whole degrees on the reading's own scale
	// code 0..3 maps to 2..5 degrees
	assign dt_limit = `DT_BASE_C + {6'h00, dt_code_r};
	// hot nibble is an offset above the lowest hot limit
	assign hot_limit = `HOT_BASE_C
		+ {4'h0, thresh_r[`THR_HOT_MSB:`THR_HOT_LSB]};
	assign change_mag = abs_diff(seq_result, baseline_r);

	// first reading only seeds the baseline
	assign dtx_hit = seq_done && base_valid_r
		&& (change_mag >= {1'b0, dt_limit});

	// negative readings never reach a positive hot limit
	assign hot_hit = seq_done && !seq_result[7]
		&& (seq_result >= hot_limit);

	// baseline moves when a change is reported, so the next
	// report needs another full step; slow drift is reported once it adds up to a full step
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			baseline_r <= 8'h00;
			base_valid_r <= 1'b0;
		end else if (seq_done && (!base_valid_r || dtx_hit)) begin
			baseline_r <= seq_result;
			base_valid_r <= 1'b1;
		end
	end

	// ============================================================
	// interrupt status, mask and output

	assign irq_set[`IRQ_EOC] = seq_done;
	assign irq_set[`IRQ_DTX] = dtx_hit;
	assign irq_set[`IRQ_HOT] = hot_hit;
	// clearing a bit with no event pending is harmless
	assign irq_clr = wr_status ? wr_data[`IRQ_W-1:0] : 3'h0;

	// sticky bits; a set in the clearing cycle wins
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			irq_stat_r <= 3'h0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
		end
	end

	// mask register, one enables the event
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			irq_mask_r <= 3'h0;
		end else if (wr_mask) begin
			// a masked event still sets its status bit, only irq_o ignores it
			irq_mask_r <= wr_data[`IRQ_W-1:0];
		end
	end

	// registered level, one cycle behind the status bits
	// the extra flop keeps irq_o free of decode glitches
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_stat_r & irq_mask_r);
		end
	end

	// ============================================================
	// read decode, unmapped words read zero with an error

	always @* begin
		rd_data = 8'h00;
		case (rd_idx)
			`IDX_ACQ_CTRL: begin
				// start and done come from their own flops, not spare_r
				rd_data = spare_r;
				rd_data[`ACQ_START_BIT] = start_r;
				rd_data[`ACQ_DONE_BIT] = done_r;
				rd_data[`ACQ_DT_MSB:`ACQ_DT_LSB] = dt_code_r;
			end
			`IDX_THRESH: begin
				rd_data = thresh_r;
			end
			`IDX_IRQ_STATUS: begin
				// raw sticky bits, mask not applied
				rd_data = {5'h00, irq_stat_r};
			end
			`IDX_IRQ_MASK: begin
				rd_data = {5'h00, irq_mask_r};
			end
			`IDX_TEMP_VIEW: begin
				// latest reading, for software polling
				rd_data = seq_result;
			end
			default: begin
				rd_data = 8'h00;
			end
		endcase
	end

endmodule // thermistor_acquire_control
`default_nettype wire

// >>> verif/thermistor_acquire_assertions.sv
// concurrent checks on the acquisition control block ports
// assumes one clock domain and the header constants on the include path
`timescale 1ns/100ps
`default_nettype none
`include "thermistor_consts.vh"

module thermistor_acquire_checker (
	// clock and reset
	input wire clk_i,
	input wire reset_n_i,
	// write side
	input wire awvalid_i,
	input wire awready_o,
	input wire [`AXI_ADDR_W-1:0] awaddr_i,
	input wire wvalid_i,
	input wire wready_o,
	input wire [`AXI_DATA_W-1:0] wdata_i,
	input wire [3:0] wstrb_i,
	input wire bvalid_o,
	input wire bready_i,
	input wire [1:0] bresp_o,
	// read side
	input wire arvalid_i,
	input wire arready_o,
	input wire [`AXI_ADDR_W-1:0] araddr_i,
	input wire rvalid_o,
	input wire rready_i,
	input wire [`AXI_DATA_W-1:0] rdata_o,
	input wire [1:0] rresp_o,
	// adc and interrupt
	input wire conv_req_o,
	input wire conv_valid_i,
	input wire irq_o
);
	// ============================================================
	// helper logic
	logic [`IDX_W-1:0] rd_idx_r; // index of the read in flight
	logic mapped; // read index hits a register
	logic ctrl_wr; // control write taken whole in one edge
	assign mapped = (rd_idx_r == `IDX_ACQ_CTRL) || (rd_idx_r == `IDX_THRESH) ||
		(rd_idx_r == `IDX_IRQ_STATUS) || (rd_idx_r == `IDX_IRQ_MASK) ||
		(rd_idx_r == `IDX_TEMP_VIEW);
	// only the paired aw/w case is watched, the bench always offers both
	assign ctrl_wr = awvalid_i && awready_o && wvalid_i && wready_o && wstrb_i[0] &&
		(awaddr_i[7:2] == `IDX_ACQ_CTRL);
	// remember the read index at the edge that takes it
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_idx_r <= 6'h00;
		end else if (arvalid_i && arready_o) begin
			rd_idx_r <= araddr_i[7:2];
		end
	end

	// ============================================================
	// assertions
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	bvalid_hold_a: assert property (bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
		else $error("write response dropped or changed");
	rvalid_hold_a: assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
		else $error("read data dropped or changed");
	rdata_upper_a: assert property (rvalid_o |-> rdata_o[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	start_launch_a: assert property (ctrl_wr && wdata_i[7] && !conv_req_o |-> ##[1:4] conv_req_o)
		else $error("start write did not request a conversion");
	start_zero_a: assert property (ctrl_wr && !wdata_i[7] && !conv_req_o |=> !conv_req_o [*3])
		else $error("zero start write launched a conversion");
	req_hold_a: assert property (conv_req_o && !conv_valid_i |=> conv_req_o)
		else $error("conversion request dropped early");
	req_end_a: assert property (conv_req_o && conv_valid_i |=> !conv_req_o)
		else $error("conversion request not ended by result");
	busy_bits_a: assert property ($rose(rvalid_o) && rd_idx_r == `IDX_ACQ_CTRL &&
		$past(conv_req_o) && conv_req_o |-> rdata_o[7] && !rdata_o[5])
		else $error("start or done bit wrong while busy");
	read_resp_a: assert property ($rose(rvalid_o) |->
		rresp_o == (mapped ? 2'h0 : 2'h2) && (mapped || rdata_o == 32'h00000000))
		else $error("read response wrong for address");
	// ============================================================
	// covers
	conv_c: cover property ($rose(conv_req_o));
	irq_c: cover property ($rose(irq_o));
	slverr_c: cover property ($rose(rvalid_o) && !mapped);
endmodule // thermistor_acquire_checker

bind thermistor_acquire_control thermistor_acquire_checker chk (.clk_i(clk_i),
	.reset_n_i(reset_n_i), .awvalid_i(awvalid_i), .awready_o(awready_o),
	.awaddr_i(awaddr_i), .wvalid_i(wvalid_i), .wready_o(wready_o), .wdata_i(wdata_i),
	.wstrb_i(wstrb_i), .bvalid_o(bvalid_o), .bready_i(bready_i), .bresp_o(bresp_o),
	.arvalid_i(arvalid_i), .arready_o(arready_o), .araddr_i(araddr_i),
	.rvalid_o(rvalid_o), .rready_i(rready_i), .rdata_o(rdata_o), .rresp_o(rresp_o),
	.conv_req_o(conv_req_o), .conv_valid_i(conv_valid_i), .irq_o(irq_o));
`default_nettype wire

// >>> verif/thermistor_acquire_control_bench.sv
// self-checking bench for the acquisition control block
// assumes the bench acts as axi4-lite master and as the adc
`timescale 1ns/100ps
`default_nettype none

module thermistor_acquire_control_bench;
	// ============================================================
	// signals
	logic clk_i = 1'h0;
	logic reset_n_i = 1'h0;
	logic awvalid_i = 1'h0, wvalid_i = 1'h0, bready_i = 1'h0;
	logic arvalid_i = 1'h0, rready_i = 1'h0, conv_valid_i = 1'h0;
	logic [7:0] awaddr_i = 8'h00, araddr_i = 8'h00, conv_data_i = 8'h00;
	logic [31:0] wdata_i = 32'h00000000;
	logic [3:0] wstrb_i = 4'hF;
	wire awready_o, wready_o, bvalid_o, arready_o, rvalid_o, conv_req_o, irq_o;
	wire [1:0] bresp_o, rresp_o;
	wire [31:0] rdata_o;
	int num_errors = 0;
	int total_checks = 0;
	logic [1:0] dt = 2'h0; // change threshold code in use
	logic [7:0] base; // expected baseline reading

	thermistor_acquire_control DUT (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.awvalid_i(awvalid_i), .awready_o(awready_o), .awaddr_i(awaddr_i),
		.wvalid_i(wvalid_i), .wready_o(wready_o), .wdata_i(wdata_i), .wstrb_i(wstrb_i),
		.bvalid_o(bvalid_o), .bready_i(bready_i), .bresp_o(bresp_o),
		.arvalid_i(arvalid_i), .arready_o(arready_o), .araddr_i(araddr_i),
		.rvalid_o(rvalid_o), .rready_i(rready_i), .rdata_o(rdata_o), .rresp_o(rresp_o),
		.conv_req_o(conv_req_o), .conv_valid_i(conv_valid_i), .conv_data_i(conv_data_i),
		.irq_o(irq_o));

	// 100 MHz clock
	always #5 clk_i = !clk_i;

	// ============================================================
	// tasks
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one write, waits for the response, no fixed latency assumed
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic fin;
		fin = 1'h0;
		@(posedge clk_i);
		awaddr_i <= a;
		wdata_i <= d;
		awvalid_i <= 1'h1;
		wvalid_i <= 1'h1;
		bready_i <= 1'h1;
		while (!fin) begin
			@(posedge clk_i);
			if (awvalid_i && awready_o) awvalid_i <= 1'h0;
			if (wvalid_i && wready_o) wvalid_i <= 1'h0;
			if (bvalid_o && bready_i) begin
				fin = 1'h1;
				bready_i <= 1'h0;
				chk({30'h0, bresp_o}, {30'h0, er});
			end
		end
	endtask
	// one read, compares data and response
	task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic fin;
		fin = 1'h0;
		@(posedge clk_i);
		araddr_i <= a;
		arvalid_i <= 1'h1;
		rready_i <= 1'h1;
		while (!fin) begin
			@(posedge clk_i);
			if (arvalid_i && arready_o) arvalid_i <= 1'h0;
			if (rvalid_o && rready_i) begin
				fin = 1'h1;
				rready_i <= 1'h0;
				chk(rdata_o, ed);
				chk({30'h0, rresp_o}, {30'h0, er});
			end
		end
	endtask
	// full acquisition: start, busy view, adc pulse, done view, status, clear
	task conv(input logic [7:0] d, input logic [2:0] es);
		wr(8'h34, {24'h0, 6'h20, dt}, 2'h0);
		rd(8'h34, {24'h0, 6'h20, dt}, 2'h0);
		chk({31'h0, conv_req_o}, 32'h1);
		// a second start while busy must not queue another conversion
		wr(8'h34, {24'h0, 6'h20, dt}, 2'h0);
		conv_data_i <= d;
		conv_valid_i <= 1'h1;
		@(posedge clk_i);
		conv_valid_i <= 1'h0;
		repeat (3) @(posedge clk_i);
		rd(8'h34, {24'h0, 6'h08, dt}, 2'h0);
		rd(8'h44, {29'h0, es}, 2'h0);
		chk({31'h0, irq_o}, 32'h1);
		wr(8'h44, 32'h7, 2'h0);
		rd(8'h44, 32'h0, 2'h0);
		chk({31'h0, irq_o}, 32'h0);
	endtask
	task give_verdict;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// ============================================================
	// watchdog, the tests need well under 5000 cycles
	initial begin
		#200000;
		num_errors++;
		give_verdict;
	end

	// ============================================================
	// test sequence
	initial begin
		repeat (2) @(posedge clk_i);
		reset_n_i <= 1'h1;
		rd(8'h34, 32'h20, 2'h0);
		rd(8'h38, 32'h78, 2'h0);
		rd(8'h44, 32'h0, 2'h0);
		rd(8'h48, 32'h0, 2'h0);
		rd(8'h4C, 32'h0, 2'h0);
		rd(8'hFC, 32'h0, 2'h2);
		wr(8'hF0, 32'hFF, 2'h2);
		wr(8'h38, 32'h73, 2'h0);
		rd(8'h38, 32'h73, 2'h0);
		// low byte lane off: answered, nothing stored
		wstrb_i <= 4'hE;
		wr(8'h38, 32'h11, 2'h0);
		wstrb_i <= 4'hF;
		rd(8'h38, 32'h73, 2'h0);
		wr(8'h34, 32'h00, 2'h0);
		rd(8'h34, 32'h20, 2'h0);
		chk({31'h0, conv_req_o}, 32'h0);
		wr(8'h34, 32'h03, 2'h0);
		rd(8'h34, 32'h23, 2'h0);
		wr(8'h48, 32'h7, 2'h0);
		dt = 2'h0;
		base = 8'h14;
		conv(base, 3'h1); // first reading only seeds the baseline
		for (int c = 0; c < 4; c++) begin
			dt = c[1:0];
			conv(base + 8'h01 + {6'h0, dt}, 3'h1);
			conv(base + 8'h02 + {6'h0, dt}, 3'h3);
			base = base + 8'h02 + {6'h0, dt};
		end
		// hot threshold code 3 is 45 degrees, 44 raises only the change event
		conv(8'h2C, 3'h3);
		conv(8'h2D, 3'h5);
		// latest reading view holds the last result
		rd(8'h4C, 32'h2D, 2'h0);
		give_verdict;
	end
endmodule // thermistor_acquire_control_bench
`default_nettype wire
